// ===== design/cmon_pkg.sv
// shared constants and carrier types for the conflict monitor fault logic
package cmon_pkg;
  localparam int CHANNELS = 18;
  localparam int MS_W = 11;
  localparam int CNT_W = 15;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // timebase: one tick per millisecond at a 40 ns clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_MS = 1;
  localparam int MS_TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
  // qualification and fault times in milliseconds
  localparam logic [MS_W-1:0] FIELD_ON_MS = 11'h1F4;      // 500 ms
  localparam logic [MS_W-1:0] INHIBIT_ON_MS = 11'h226;    // 550 ms
  localparam logic [MS_W-1:0] RED_FAIL_ENH_MS = 11'h546;  // 1350 ms
  localparam logic [MS_W-1:0] RED_FAIL_STD_MS = 11'h352;  // 850 ms
  localparam logic [MS_W-1:0] WD_FAST_MS = 11'h3E8;       // 1.0 s
  localparam logic [MS_W-1:0] WD_SLOW_MS = 11'h5DC;       // 1.5 s
  localparam logic [MS_W-1:0] BROWNOUT_HIGH_MS = 11'h190; // 400 ms
  localparam logic [MS_W-1:0] BROWNOUT_LOW_MS = 11'h050;  // 80 ms
  // register offsets
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h8;

  typedef struct packed {
    logic high;
    logic low;
  } sense_type;

  typedef struct packed {
    logic [CHANNELS-1:0] red_high;
    logic [CHANNELS-1:0] red_low;
    logic [CHANNELS-1:0] yellow_high;
    logic [CHANNELS-1:0] yellow_low;
    logic [CHANNELS-1:0] green_high;
    logic [CHANNELS-1:0] green_low;
  } field_sense_type;

  typedef struct packed {
    logic dropout_high_set;
    logic restore_high_set;
    logic dropout_low_set;
    logic restore_low_set;
  } ac_sense_type;

  typedef struct packed {
    logic red_fail_enhanced;
    logic watchdog_fast;
    logic brownout_high;
    logic watchdog_latch;
    logic relay_invert;
    logic [CHANNELS-1:0] red_fail_enable;
    logic [CHANNELS-1:0][CHANNELS-1:0] permissive;
  } config_type;

  typedef struct packed {
    logic [CHANNELS-1:0] red;
    logic [CHANNELS-1:0] yellow;
    logic [CHANNELS-1:0] green;
  } lamps_type;

  typedef struct packed {
    logic ac_power;
    logic dc_supply_fail_indicator;
    logic watchdog_error_indicator;
    logic conflict;
    logic red_fail;
    logic dual_indication;
    logic clearance;
    logic program_card_absent_indicator;
    logic diagnostic_fail;
  } status_ind_type;

  typedef struct packed {
    logic diag;
    logic dc;
    logic dual;
    logic conflict;
    logic watchdog;
    logic red;
    logic cable;
    logic card;
  } fault_type;

  typedef struct packed {
    logic brownout;
    fault_type fault;
  } event_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [MS_W-1:0] count;
    logic on;
  } qual_state_type;

  typedef struct packed {
    logic [CNT_W-1:0] cycle_cnt;
    logic ms_tick;
    logic [CHANNELS-1:0][MS_W-1:0] red_timer;
    logic [MS_W-1:0] wd_timer;
    logic wd_last;
    logic [MS_W-1:0] bo_timer;
    logic brownout;
    fault_type fault;
    logic flash;
    lamps_type capture;
    logic [CHANNELS-1:0] failed;
    event_type status;
    event_type mask;
    logic [DATA_W-1:0] rdata;
  } monitor_state_type;

  localparam qual_state_type QUAL_RESET = '0;
  localparam monitor_state_type MONITOR_RESET = '0;
endpackage : cmon_pkg

// ===== design/input_qualifier.sv
// duration qualifier for one comparator-sensed input
`timescale 1ns/100ps
module input_qualifier #(
  parameter logic [cmon_pkg::MS_W-1:0] ON_MS = cmon_pkg::FIELD_ON_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ms_tick,
  input wire logic above_high,
  input wire logic below_low,
  output logic on
);
  cmon_pkg::qual_state_type st, next_st;

  always_comb begin
    next_st = st;
    if (below_low) begin
      next_st = cmon_pkg::QUAL_RESET;
    end else if (above_high) begin
      if (st.count == ON_MS) begin
        next_st.on = 1'b1;
      end else if (ms_tick) begin
        next_st.count = st.count + 11'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= cmon_pkg::QUAL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign on = st.on;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_low_clears;
    below_low |=> !on;
  endproperty
  a_low_clears: assert property (p_low_clears) else $error("input on after low level");

  property p_on_time;
    $rose(on) |-> $past(st.count) == ON_MS && $past(above_high);
  endproperty
  a_on_time: assert property (p_on_time) else $error("input qualified early");
endmodule : input_qualifier

// ===== design/conflict_monitor.sv
// fault supervision logic of an 18-channel conflict monitor
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module conflict_monitor #(
  parameter int TICK_CYCLES = cmon_pkg::MS_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire cmon_pkg::reg_req_type reg_req,
  output logic [cmon_pkg::DATA_W-1:0] rdata,
  output logic irq,
  input wire cmon_pkg::field_sense_type field,
  input wire cmon_pkg::sense_type red_enable,
  input wire cmon_pkg::sense_type relay_common_input,
  input wire cmon_pkg::sense_type inhibit1,
  input wire cmon_pkg::sense_type inhibit2,
  input wire cmon_pkg::ac_sense_type ac_line,
  input wire cmon_pkg::config_type cfg,
  input wire logic card_present,
  input wire logic red_interface_cable,
  input wire logic watchdog_in,
  input wire logic power_interrupt,
  input wire logic dc_fail_in,
  input wire logic diag_fail_in,
  input wire logic front_reset,
  input wire logic remote_reset,
  output cmon_pkg::status_ind_type indicators,
  output cmon_pkg::lamps_type channel_lamps,
  output logic [cmon_pkg::CHANNELS-1:0] failed_channel,
  output logic flash_command
);
  cmon_pkg::monitor_state_type st, next_st;
  cmon_pkg::lamps_type live;
  cmon_pkg::sense_type relay_sense;
  logic [cmon_pkg::CHANNELS-1:0] active, dark, dual, conflict_mark;
  logic red_en_on, relay_on, inh1_on, inh2_on;
  logic red_check, reset_cmd, disturb, lowline, restored;
  logic [cmon_pkg::MS_W-1:0] red_limit, wd_limit, bo_limit;

  // per-channel qualification of every field input
  genvar g;
  generate
    for (g = 0; g < cmon_pkg::CHANNELS; g++) begin : g_chan
      input_qualifier #(.ON_MS(cmon_pkg::FIELD_ON_MS)) u_red (
        .clk(clk), .rst_b(rst_b), .ms_tick(st.ms_tick),
        .above_high(field.red_high[g]), .below_low(field.red_low[g]),
        .on(live.red[g]));
      input_qualifier #(.ON_MS(cmon_pkg::FIELD_ON_MS)) u_yellow (
        .clk(clk), .rst_b(rst_b), .ms_tick(st.ms_tick),
        .above_high(field.yellow_high[g]), .below_low(field.yellow_low[g]),
        .on(live.yellow[g]));
      input_qualifier #(.ON_MS(cmon_pkg::FIELD_ON_MS)) u_green (
        .clk(clk), .rst_b(rst_b), .ms_tick(st.ms_tick),
        .above_high(field.green_high[g]), .below_low(field.green_low[g]),
        .on(live.green[g]));
    end
  endgenerate

  input_qualifier #(.ON_MS(cmon_pkg::FIELD_ON_MS)) u_red_enable (
    .clk(clk), .rst_b(rst_b), .ms_tick(st.ms_tick),
    .above_high(red_enable.high), .below_low(red_enable.low), .on(red_en_on));

  // jumper swaps which comparator means active
  assign relay_sense.high = cfg.relay_invert ? relay_common_input.low
                                             : relay_common_input.high;
  assign relay_sense.low = cfg.relay_invert ? relay_common_input.high
                                            : relay_common_input.low;

  input_qualifier #(.ON_MS(cmon_pkg::FIELD_ON_MS)) u_relay (
    .clk(clk), .rst_b(rst_b), .ms_tick(st.ms_tick),
    .above_high(relay_sense.high), .below_low(relay_sense.low), .on(relay_on));

  input_qualifier #(.ON_MS(cmon_pkg::INHIBIT_ON_MS)) u_inhibit1 (
    .clk(clk), .rst_b(rst_b), .ms_tick(st.ms_tick),
    .above_high(inhibit1.high), .below_low(inhibit1.low), .on(inh1_on));

  input_qualifier #(.ON_MS(cmon_pkg::INHIBIT_ON_MS)) u_inhibit2 (
    .clk(clk), .rst_b(rst_b), .ms_tick(st.ms_tick),
    .above_high(inhibit2.high), .below_low(inhibit2.low), .on(inh2_on));

  assign red_limit = cfg.red_fail_enhanced ? cmon_pkg::RED_FAIL_ENH_MS
                                           : cmon_pkg::RED_FAIL_STD_MS;
  assign wd_limit = cfg.watchdog_fast ? cmon_pkg::WD_FAST_MS
                                      : cmon_pkg::WD_SLOW_MS;
  assign bo_limit = cfg.brownout_high ? cmon_pkg::BROWNOUT_HIGH_MS
                                      : cmon_pkg::BROWNOUT_LOW_MS;
  assign lowline = cfg.brownout_high ? ac_line.dropout_high_set
                                     : ac_line.dropout_low_set;
  assign restored = cfg.brownout_high ? ac_line.restore_high_set
                                      : ac_line.restore_low_set;

  assign red_check = red_en_on && !inh1_on && !inh2_on && !relay_on;
  assign reset_cmd = front_reset || remote_reset;
  assign disturb = power_interrupt || st.brownout;

  assign active = live.green | live.yellow;
  assign dark = ~(live.red | live.yellow | live.green);
  assign dual = (live.red & live.yellow) | (live.red & live.green)
              | (live.yellow & live.green);

  always_comb begin
    conflict_mark = '0;
    for (int i = 0; i < cmon_pkg::CHANNELS; i++) begin
      for (int j = 0; j < cmon_pkg::CHANNELS; j++) begin
        if (i != j && active[i] && active[j] && !cfg.permissive[i][j]) begin
          conflict_mark[i] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    logic [cmon_pkg::CHANNELS-1:0] red_set;
    logic [cmon_pkg::CHANNELS-1:0] dual_set;
    logic wd_set;
    cmon_pkg::fault_type sets;
    cmon_pkg::event_type events;
    red_set = '0;
    dual_set = '0;
    wd_set = 1'b0;
    sets = '0;
    events = '0;
    next_st = st;

    // millisecond timebase
    next_st.ms_tick = 1'b0;
    if (st.cycle_cnt == cmon_pkg::CNT_W'(TICK_CYCLES - 1)) begin
      next_st.cycle_cnt = '0;
      next_st.ms_tick = 1'b1;
    end else begin
      next_st.cycle_cnt = st.cycle_cnt + 15'h0001;
    end

    // a dark channel times out into a red fail
    for (int i = 0; i < cmon_pkg::CHANNELS; i++) begin
      if (red_check && cfg.red_fail_enable[i] && dark[i]) begin
        if (st.red_timer[i] == red_limit) begin
          red_set[i] = 1'b1;
        end else if (st.ms_tick) begin
          next_st.red_timer[i] = st.red_timer[i] + 11'h001;
        end
      end else begin
        next_st.red_timer[i] = '0;
      end
    end

    // watchdog: any transition restarts the window
    next_st.wd_last = watchdog_in;
    if (watchdog_in != st.wd_last || disturb) begin
      next_st.wd_timer = '0;
    end else if (st.wd_timer == wd_limit) begin
      wd_set = 1'b1;
    end else if (st.ms_tick) begin
      next_st.wd_timer = st.wd_timer + 11'h001;
    end

    // low line qualified by time, released at the restore level
    if (st.brownout) begin
      if (restored) begin
        next_st.brownout = 1'b0;
        next_st.bo_timer = '0;
      end
    end else if (!lowline) begin
      next_st.bo_timer = '0;
    end else if (st.bo_timer == bo_limit) begin
      next_st.brownout = 1'b1;
    end else if (st.ms_tick) begin
      next_st.bo_timer = st.bo_timer + 11'h001;
    end

    dual_set = dual & {cmon_pkg::CHANNELS{red_en_on && !relay_on}};
    sets.card = !card_present;
    sets.cable = !red_interface_cable;
    sets.red = |red_set;
    sets.watchdog = wd_set;
    sets.conflict = |conflict_mark;
    sets.dual = |dual_set;
    sets.dc = dc_fail_in;
    sets.diag = diag_fail_in;

    // faults hold until reset, watchdog fault with latch off also until a disturb; a cause still present sets again
    if (reset_cmd) begin
      next_st.fault = '0;
    end
    if (!cfg.watchdog_latch && disturb) begin
      next_st.fault.watchdog = 1'b0;
    end
    next_st.fault = next_st.fault | sets;
    next_st.flash = (|next_st.fault) || next_st.brownout;

    // freeze channel status and failing channels once in fault mode
    if (!(|st.fault)) begin
      next_st.capture = live;
      next_st.failed = sets.conflict ? active : (red_set | dual_set);
    end

    // sticky events, set wins over a write-one clear
    events.brownout = next_st.brownout && !st.brownout;
    events.fault = next_st.fault & ~st.fault;
    if (reg_req.wr && reg_req.addr == cmon_pkg::REG_STATUS) begin
      next_st.status = st.status & ~reg_req.wdata[$bits(cmon_pkg::event_type)-1:0];
    end
    next_st.status = next_st.status | events;
    if (reg_req.wr && reg_req.addr == cmon_pkg::REG_MASK) begin
      next_st.mask = reg_req.wdata[$bits(cmon_pkg::event_type)-1:0];
    end

    // read data valid only in the cycle after the strobe
    next_st.rdata = '0;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        cmon_pkg::REG_STATUS: next_st.rdata = cmon_pkg::DATA_W'(st.status);
        cmon_pkg::REG_MASK: next_st.rdata = cmon_pkg::DATA_W'(st.mask);
        cmon_pkg::REG_STATE: next_st.rdata = cmon_pkg::DATA_W'({st.flash, st.brownout, st.fault});
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= cmon_pkg::MONITOR_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq = |(st.status & st.mask);
  assign flash_command = st.flash;
  assign channel_lamps = st.capture;
  assign failed_channel = st.failed;
  assign indicators.ac_power = !st.brownout;
  assign indicators.dc_supply_fail_indicator = st.fault.dc;
  assign indicators.watchdog_error_indicator = st.fault.watchdog;
  assign indicators.conflict = st.fault.conflict;
  assign indicators.red_fail = st.fault.red;
  assign indicators.dual_indication = st.fault.dual;
  // yellow clearance timing is not part of this block
  assign indicators.clearance = 1'b0;
  assign indicators.program_card_absent_indicator = st.fault.card;
  assign indicators.diagnostic_fail = st.fault.diag || st.fault.cable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_card_set;
    !card_present |=> st.fault.card && flash_command;
  endproperty
  a_card_set: assert property (p_card_set) else $error("card absence not faulted");

  property p_card_hold;
    st.fault.card && !(reset_cmd && card_present) |=> st.fault.card;
  endproperty
  a_card_hold: assert property (p_card_hold) else $error("card fault dropped");

  property p_cable_flash;
    !red_interface_cable ##1 red_interface_cable && !reset_cmd |=> flash_command;
  endproperty
  a_cable_flash: assert property (p_cable_flash) else $error("cable fault not latched");

  property p_red_gate;
    !st.fault.red && !red_check |=> !st.fault.red;
  endproperty
  a_red_gate: assert property (p_red_gate) else $error("red fail while gated off");

  property p_fault_hold;
    st.fault.conflict && !reset_cmd |=> st.fault.conflict;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("conflict dropped without reset");

  property p_capture_hold;
    (|st.fault) |=> $stable(st.capture) && $stable(st.failed);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("capture changed in fault");

  property p_wd_latch;
    cfg.watchdog_latch && st.fault.watchdog && !reset_cmd |=> st.fault.watchdog;
  endproperty
  a_wd_latch: assert property (p_wd_latch) else $error("latched watchdog fault lost");

  property p_wd_autoclr;
    !cfg.watchdog_latch && st.fault.watchdog && disturb |=> !st.fault.watchdog;
  endproperty
  a_wd_autoclr: assert property (p_wd_autoclr) else $error("watchdog fault kept");

  property p_wd_time;
    $rose(st.fault.watchdog) |-> $past(st.wd_timer) == $past(wd_limit);
  endproperty
  a_wd_time: assert property (p_wd_time) else $error("watchdog fault at wrong time");

  property p_bo_time;
    $rose(st.brownout) |-> $past(st.bo_timer) == $past(bo_limit);
  endproperty
  a_bo_time: assert property (p_bo_time) else $error("brown-out at wrong time");

  // an inhibit only blinds the red-fail check, never the conflict check
  property p_inh_conf;
    (inh1_on || inh2_on) && (|conflict_mark) |=> st.fault.conflict;
  endproperty
  a_inh_conf: assert property (p_inh_conf) else $error("inhibit hid conflict");

  property p_lamp_track;
    !(|st.fault) |=> channel_lamps == $past(live);
  endproperty
  a_lamp_track: assert property (p_lamp_track) else $error("lamps not live");

  property p_cable_set;
    !red_interface_cable |=> st.fault.cable && flash_command;
  endproperty
  a_cable_set: assert property (p_cable_set) else $error("cable fault not set");

  // with the jumper a high relay common line means not active
  property p_relay_pol;
    cfg.relay_invert && relay_common_input.high |=> !relay_on;
  endproperty
  a_relay_pol: assert property (p_relay_pol) else $error("jumper ignored");

  property p_bo_clear;
    st.brownout && restored |=> !st.brownout;
  endproperty
  a_bo_clear: assert property (p_bo_clear) else $error("brown-out kept");

  c_dual: cover property ($rose(st.fault.dual));
  c_conflict: cover property ($rose(st.fault.conflict));
  c_red_fail: cover property ($rose(st.fault.red));
  c_brownout: cover property ($rose(st.brownout));
  c_watchdog: cover property ($rose(st.fault.watchdog));
endmodule : conflict_monitor

// ===== verification/field_source.sv
// cabinet field source model: lamp commands become comparator flag pairs
`timescale 1ns/100ps
module field_source (
  input wire logic clk,
  input wire cmon_pkg::lamps_type cmd,
  input wire logic [3:0] aux,
  input wire logic wd_run,
  output cmon_pkg::field_sense_type field,
  output cmon_pkg::sense_type red_enable,
  output cmon_pkg::sense_type relay_common_input,
  output cmon_pkg::sense_type inhibit1,
  output cmon_pkg::sense_type inhibit2,
  output logic watchdog_in
);
  int wd_cnt;
  initial begin
    field = {3{18'h00000, 18'h3FFFF}};
    {red_enable, relay_common_input, inhibit1, inhibit2} = 8'h55;
    watchdog_in = 1'b0;
    wd_cnt = 0;
  end
  // a line is above its high level or below its low level, never both
  always @(posedge clk) begin
    field <= {cmd.red, ~cmd.red, cmd.yellow, ~cmd.yellow, cmd.green, ~cmd.green};
    red_enable <= {aux[0], ~aux[0]};
    relay_common_input <= {aux[1], ~aux[1]};
    inhibit1 <= {aux[2], ~aux[2]};
    inhibit2 <= {aux[3], ~aux[3]};
    wd_cnt <= (wd_cnt == 999) ? 0 : wd_cnt + 1;
    // controller heartbeat: one change every 100 ms while running
    if (wd_run && wd_cnt == 999) begin
      watchdog_in <= ~watchdog_in;
    end
  end
endmodule : field_source

// ===== verification/test_conflict_monitor.sv
// self-checking bench for the conflict monitor fault logic
`timescale 1ns/100ps
module test_conflict_monitor;
  typedef struct {
    logic [53:0] cmd;
    int hold;
    logic [53:0] exp;
  } row_type;
  localparam logic [53:0] G0 = 54'h1;
  localparam logic [53:0] G01 = 54'h3;
  localparam logic [53:0] R17 = {18'h20000, 36'h0};
  localparam logic [53:0] MIX = {18'h20000, 18'h00020, 18'h00001};
  localparam logic [323:0] ALLOW = '1;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  cmon_pkg::reg_req_type reg_req = '0;
  cmon_pkg::lamps_type cmd = '0;
  logic [3:0] aux = 4'h0;
  logic wd_run = 1'b1;
  cmon_pkg::ac_sense_type ac_line = 4'h5;
  cmon_pkg::config_type cfg = '0;
  logic card_present = 1'b1;
  logic cable = 1'b1;
  logic power_interrupt = 1'b0;
  logic [1:0] fail_in = 2'h0;
  logic front_reset = 1'b0;
  logic remote_reset = 1'b0;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [3:0] c;
  logic irq;
  logic watchdog_in;
  logic flash_command;
  logic [17:0] failed_channel;
  cmon_pkg::field_sense_type field;
  cmon_pkg::sense_type red_enable, relay, inh1, inh2;
  cmon_pkg::status_ind_type indicators;
  cmon_pkg::lamps_type channel_lamps;
  int err_total = 0;
  int checks_done = 0;
  row_type rows [6] = '{'{0, 10, 0}, '{G0, 300, 0}, '{0, 10, 0}, '{G0 | R17, 300, 0},
    '{MIX, 520, MIX}, '{0, 10, 0}};
  logic [15:0] st_exp [4] = '{16'h0201, 16'h0202, 16'h0240, 16'h0280};
  logic [8:0] ind_exp [4] = '{9'h102, 9'h101, 9'h180, 9'h101};

  initial begin
    forever #20 clk = ~clk;
  end

  field_source partner (.clk(clk), .cmd(cmd), .aux(aux), .wd_run(wd_run), .field(field),
    .red_enable(red_enable), .relay_common_input(relay), .inhibit1(inh1), .inhibit2(inh2),
    .watchdog_in(watchdog_in));

  conflict_monitor #(.TICK_CYCLES(10)) dut (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
    .rdata(rdata), .irq(irq), .field(field), .red_enable(red_enable),
    .relay_common_input(relay), .inhibit1(inh1), .inhibit2(inh2), .ac_line(ac_line),
    .cfg(cfg), .card_present(card_present), .red_interface_cable(cable),
    .watchdog_in(watchdog_in), .power_interrupt(power_interrupt), .dc_fail_in(fail_in[0]),
    .diag_fail_in(fail_in[1]), .front_reset(front_reset), .remote_reset(remote_reset),
    .indicators(indicators), .channel_lamps(channel_lamps),
    .failed_channel(failed_channel), .flash_command(flash_command));

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic ms(input int n);
    repeat (n * 10) @(posedge clk);
  endtask : ms

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    reg_req <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1 v = rdata;
  endtask : rd

  task automatic chk_state(input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    rd(cmon_pkg::REG_STATE, v);
    check(64'(v & m), 64'(e));
  endtask : chk_state

  task automatic setup(input logic [4:0] sw, input logic [17:0] en, input logic [323:0] pm,
    input logic [3:0] a);
    @(posedge clk);
    rst_b <= 1'b0;
    cfg <= {sw, en, pm};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    aux <= a;
  endtask : setup

  task automatic pulse(input logic remote);
    @(posedge clk);
    if (remote) begin
      remote_reset <= 1'b1;
    end else begin
      front_reset <= 1'b1;
    end
    @(posedge clk);
    front_reset <= 1'b0;
    remote_reset <= 1'b0;
    ms(1);
  endtask : pulse

  initial begin
    setup(5'h00, 18'h00000, ALLOW, 4'h0);
    ms(1);
    check(64'(indicators), 64'h100);
    check(64'(flash_command), 64'h0);
    rd(cmon_pkg::REG_MASK, d);
    check(64'(d), 64'h0);
    rd(4'hC, d);
    check(64'(d), 64'h0);
    foreach (rows[i]) begin
      cmd <= rows[i].cmd;
      ms(rows[i].hold);
      check(64'(channel_lamps), 64'(rows[i].exp));
    end
    // red fail, legacy time, channel 3 dark and enabled
    setup(5'h00, 18'h00004, ALLOW, 4'h1);
    ms(1340);
    chk_state(16'h0004, 16'h0000);
    ms(20);
    chk_state(16'h0204, 16'h0204);
    check(64'(failed_channel), 64'h4);
    check(64'(indicators.red_fail), 64'h1);
    rd(cmon_pkg::REG_STATUS, d);
    check(64'(d), 64'h4);
    check(64'(irq), 64'h0);
    wr(cmon_pkg::REG_MASK, 16'h0004);
    rd(cmon_pkg::REG_MASK, d);
    check(64'(d), 64'h4);
    check(64'(irq), 64'h1);
    wr(cmon_pkg::REG_STATUS, 16'h0004);
    @(posedge clk);
    #1 check(64'(irq), 64'h0);
    // enhanced time, jumper inverts relay common, channel 2 red and green together
    cmd <= {18'h00002, 18'h00000, 18'h00002};
    setup(5'h11, 18'h00004, ALLOW, 4'h3);
    ms(1840);
    chk_state(16'h0004, 16'h0000);
    check(64'(failed_channel), 64'h2);
    check(64'(indicators.dual_indication), 64'h1);
    ms(20);
    chk_state(16'h0024, 16'h0024);
    // inhibit blocks red fail, a conflict still latches and freezes the lamps
    cmd <= G01;
    setup(5'h00, 18'h00004, ~324'h40002, 4'h5);
    ms(1400);
    chk_state(16'h0014, 16'h0010);
    check(64'(failed_channel), 64'h3);
    check(64'(indicators.conflict), 64'h1);
    cmd <= '0;
    ms(10);
    check(64'(channel_lamps), 64'(G01));
    // watchdog: fast time, latch off, then slow time with latch on
    wd_run <= 1'b0;
    setup(5'h08, 18'h00000, ALLOW, 4'h0);
    ms(990);
    chk_state(16'h0008, 16'h0000);
    ms(20);
    chk_state(16'h0008, 16'h0008);
    check(64'(indicators.watchdog_error_indicator), 64'h1);
    power_interrupt <= 1'b1;
    ms(10);
    chk_state(16'h0008, 16'h0000);
    cfg[323 + 18 + 2] <= 1'b1;
    cfg[323 + 18 + 4] <= 1'b0;
    power_interrupt <= 1'b0;
    ms(1490);
    chk_state(16'h0008, 16'h0000);
    ms(20);
    chk_state(16'h0008, 16'h0008);
    power_interrupt <= 1'b1;
    ms(10);
    power_interrupt <= 1'b0;
    ms(10);
    chk_state(16'h0008, 16'h0008);
    // brown-out: low set 80 ms, high set 400 ms
    wd_run <= 1'b1;
    setup(5'h00, 18'h00000, ALLOW, 4'h0);
    ac_line <= 4'h9;
    ms(100);
    check(64'(indicators.ac_power), 64'h1);
    ac_line <= 4'hA;
    ms(75);
    check(64'(indicators.ac_power), 64'h1);
    ms(15);
    chk_state(16'h0300, 16'h0300);
    ac_line <= 4'h5;
    ms(1);
    check(64'(indicators.ac_power), 64'h1);
    setup(5'h04, 18'h00000, ALLOW, 4'h0);
    ac_line <= 4'h9;
    ms(390);
    check(64'(indicators.ac_power), 64'h1);
    ms(20);
    check(64'(indicators.ac_power), 64'h0);
    ac_line <= 4'h5;
    setup(5'h00, 18'h00000, ALLOW, 4'h0);
    ms(1);
    // latching causes: card, cable, dc supply, diagnostic
    for (int k = 0; k < 4; k++) begin
      c = 4'h1 << k;
      card_present <= ~c[0];
      cable <= ~c[1];
      fail_in <= c[3:2];
      ms(1);
      chk_state(16'h03FF, st_exp[k]);
      check(64'(indicators), 64'(ind_exp[k]));
      check(64'(flash_command), 64'h1);
      pulse(k[0]);
      chk_state(16'h03FF, st_exp[k]);
      card_present <= 1'b1;
      cable <= 1'b1;
      fail_in <= 2'h0;
      ms(1);
      chk_state(16'h03FF, st_exp[k]);
      pulse(~k[0]);
      chk_state(16'h03FF, 16'h0000);
    end
    end_of_test();
  end
endmodule : test_conflict_monitor
